/* kwd_pkg.sv */
/*
 * Package for the keyed watchdog timer: register offset, field layout,
 * key words, timing constants and the bus request carrier.
 * Assumes a 50 MHz system clock and a 16-bit control register that
 * sits in the low half of one 32-bit Avalon-MM word.
 */
package kwd_pkg;

    // Register map, byte address on the Avalon-MM slave.
    localparam logic [3:0] KWD_CTRL_ADDR = 4'h0;

    // Control register layout.
    localparam int KWD_MODE_BIT = 15;
    localparam int KWD_RST_FLAG_BIT = 13;
    localparam int KWD_IRQ_FLAG_BIT = 12;
    localparam int KWD_SEL_LSB = 0;
    localparam int KWD_SEL_W = 3;

    // Timeout selection and reset value of the configuration.
    localparam logic [KWD_SEL_W-1:0] KWD_SEL_MAX = 3'h7;
    localparam logic KWD_MODE_RESET = 1'b0;
    localparam logic KWD_MODE_NMI = 1'b1;

    // Key words.
    localparam logic [15:0] KWD_KEY_CFG1 = 16'h3333;
    localparam logic [15:0] KWD_KEY_CFG2 = 16'hCCCC;
    localparam logic [15:0] KWD_KEY_RST1 = 16'hAAAA;
    localparam logic [15:0] KWD_KEY_RST2 = 16'h5555;

    // Longest timeout is 1.67 s at 40 MHz, scaled here to 50 MHz.
    localparam longint KWD_REF_HZ = 40000000;
    localparam longint KWD_MAX_TIME_MS = 1670;
    localparam longint KWD_CLK_HZ = 50000000;
    localparam longint KWD_MAX_CYC =
        (KWD_MAX_TIME_MS * KWD_CLK_HZ) / 1000;
    localparam int KWD_CNT_W = 27;

    // Shift between adjacent timeout selections.
    localparam int KWD_SEL_STEP = 2;

    // Length of the watchdog reset pulse in clock cycles.
    localparam int KWD_RST_PULSE = 4;

    // Avalon-MM request carrier.
    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
    } kwd_req_t;

    // Key sequence states.
    typedef enum logic [1:0] {
        KWD_IDLE = 2'b00,
        KWD_GOT1 = 2'b01,
        KWD_GOT2 = 2'b11
    } kwd_seq_t;

endpackage

/* kwd_properties.sv */
/* Port checker for the keyed watchdog.
   Assumes it is bound to kwd_top. */
`timescale 1ns/1ps
module kwd_properties
    import kwd_pkg::*;
(
    // Watched ports.
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic wdt_nmi_o,
    input wire logic wdt_rst_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // A request is pending when read or write is high.
    wire logic req = avs_read_i || avs_write_i;
    wait_first_a: assert property ($rose(req) |-> avs_waitrequest_o)
        else $error("new request not held off");
    wait_one_a: assert property (
        req && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("wait lasted over one cycle");
    hidden_count_a: assert property (avs_readdata_o[31:16] == 16'h0000
        && !avs_readdata_o[14] && avs_readdata_o[11:3] == 9'h000)
        else $error("unused read bits not zero");
    unmapped_zero_a: assert property (avs_read_i
        && !avs_waitrequest_o && avs_address_i != KWD_CTRL_ADDR
        |-> avs_readdata_o == 32'h0000_0000)
        else $error("unmapped read not zero");
    nmi_pulse_a: assert property (wdt_nmi_o |=> !wdt_nmi_o)
        else $error("interrupt pulse too long");
    rst_pulse_a: assert property ($rose(wdt_rst_o) |-> wdt_rst_o[*4])
        else $error("reset pulse too short");
    one_event_a: assert property (!(wdt_nmi_o && wdt_rst_o))
        else $error("interrupt and reset together");
    boot_quiet_a: assert property ($rose(rst_n_i) |-> !wdt_rst_o[*8])
        else $error("reset right after boot");
    // Main scenarios.
    cover property ($rose(wdt_nmi_o));
    cover property ($rose(wdt_rst_o));
    cover property (avs_write_i && !avs_waitrequest_o);
endmodule
bind kwd_top kwd_properties chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .wdt_nmi_o(wdt_nmi_o),
    .wdt_rst_o(wdt_rst_o));

/* kwd_seq.sv */
/*
 * Two-word key detector followed by an optional payload word.
 * Assumes wr_i and rd_i are one-cycle pulses of accepted accesses to
 * the control register and that data_i is valid with wr_i.
 */
`timescale 1ns/1ps
module kwd_seq
    import kwd_pkg::*;
#(
    parameter logic [15:0] KEY1 = 16'h0000,
    parameter logic [15:0] KEY2 = 16'h0000,
    parameter bit THIRD = 1'b0
)
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Access strobes.
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] data_i,
    // Result.
    output logic hit_o
);

    kwd_seq_t state_ff;
    kwd_seq_t nxt_state;

    // Any other access to the register cancels a sequence in progress.
    always_comb
    begin
        nxt_state = state_ff;
        hit_o = 1'b0;
        case (state_ff)
            KWD_IDLE:
            begin
                if (wr_i && data_i == KEY1)
                begin
                    nxt_state = KWD_GOT1;
                end
            end
            KWD_GOT1:
            begin
                if (wr_i && data_i == KEY2)
                begin
                    nxt_state = THIRD ? KWD_GOT2 : KWD_IDLE;
                    hit_o = !THIRD;
                end
                else if (wr_i || rd_i)
                begin
                    nxt_state = KWD_IDLE; // [R4] [R6]
                end
            end
            KWD_GOT2:
            begin
                if (wr_i)
                begin
                    nxt_state = KWD_IDLE;
                    hit_o = 1'b1;
                end
                else if (rd_i)
                begin
                    nxt_state = KWD_IDLE; // [R4]
                end
            end
            default:
            begin
                nxt_state = KWD_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            state_ff <= KWD_IDLE; // [R19]
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

endmodule

/* kwd_top.sv */
/*
 * Keyed watchdog timer with an Avalon-MM register slave.
 * Assumes one 50 MHz clock, a synchronous active-low power-on reset,
 * and that the rest of the system takes wdt_rst_o as an ordinary
 * system reset that does not re-sample configuration pins.
 */
// How it works
// (R1) Runs after reset, longest timeout, reset mode.
// (R2) Only one configuration write after reset.
// (R3) Configure by 3333h, CCCCh, then data.
// (R4) Only control register accesses break unlock.
// (R5) AAAAh then 5555h restarts the count.
// (R6) Restart pair cancelled by control accesses only.
// (R7) Count value never readable.
// (R8) Longest timeout about 1.67 s at 40 MHz.
// (R9) Mode bit selects NMI or system reset.
// (R10) NMI timeout sets interrupt flag, bit 12.
// (R11) NMI handler checks interrupt flag for source.
// (R12) Handler clears interrupt flag via unlock write; code clears it only on the first configuration write after reset.
// (R13) Timeout with interrupt flag set resets system.
// (R14) Watchdog reset sets reset flag, bit 13.
// (R15) Any control access clears reset flag.
// (R16) Watchdog reset leaves pin-sampled configuration alone.
// (R17) Watchdog reset otherwise acts as system reset.
// (R18) Counter ticks each clock; field selects length.
// (R19) Power-on reset clears flags and sequencers.
`timescale 1ns/1ps
module kwd_top
    import kwd_pkg::*;
#(
    parameter longint MAX_CYC = KWD_MAX_CYC
)
(
    // Clock and power-on reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Avalon-MM slave.
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Watchdog events.
    output logic wdt_nmi_o,
    output logic wdt_rst_o
);

    kwd_req_t req;
    logic ack_ff;
    logic [31:0] rdata_ff;
    logic sel_ctrl;
    logic ctrl_wr;
    logic ctrl_rd;
    logic cfg_hit;
    logic kick_hit;
    logic cfg_done_ff;
    logic mode_ff;
    logic [KWD_SEL_W-1:0] tsel_ff;
    logic irq_flag_ff;
    logic rst_flag_ff;
    logic [KWD_CNT_W-1:0] cnt_ff;
    logic [KWD_CNT_W-1:0] limit;
    logic timeout;
    logic nmi_ff;
    logic [2:0] rst_cnt_ff;
    logic wdt_rst_ff;
    logic sys_rst_n;
    logic [15:0] ctrl_view;

    // Pack the bus request.
    assign req = '{avs_read_i, avs_write_i, avs_address_i, avs_writedata_i};

    // Returns the terminal count for a timeout selection.
    function automatic logic [KWD_CNT_W-1:0] sel_limit(
        input logic [KWD_SEL_W-1:0] sel
    );
        logic [KWD_CNT_W-1:0] top;
        logic [5:0] sh;
        top = KWD_CNT_W'(MAX_CYC - 1);
        sh = 6'((KWD_SEL_MAX - sel) * KWD_SEL_STEP);
        sel_limit = top >> sh;
    endfunction

    // Address decode; each access takes exactly one wait cycle.
    assign sel_ctrl = (req.address == KWD_CTRL_ADDR);
    assign avs_waitrequest_o = (req.read || req.write) && !ack_ff;
    // A control access takes effect at the edge that completes it.
    assign ctrl_wr = req.write && ack_ff && sel_ctrl;
    assign ctrl_rd = req.read && ack_ff && sel_ctrl;
    assign avs_readdata_o = rdata_ff;

    // The watchdog's own reset also clears the sequencers, configuration and counter, not the flags, bus handshake or pulse.
    assign sys_rst_n = rst_n_i && !wdt_rst_ff; // [R17]

    // Control register view; the count itself is never exposed.
    assign ctrl_view = {mode_ff, 1'b0, rst_flag_ff, irq_flag_ff,
                        9'h000, tsel_ff}; // [R7]

    // Configuration unlock: two keys then the data word.
    kwd_seq #(
        .KEY1(KWD_KEY_CFG1),
        .KEY2(KWD_KEY_CFG2),
        .THIRD(1'b1)
    ) u_cfg_seq (
        .clk_i(clk_i),
        .rst_n_i(sys_rst_n),
        .wr_i(ctrl_wr),
        .rd_i(ctrl_rd),
        .data_i(req.writedata[15:0]),
        .hit_o(cfg_hit)
    ); // [R3] [R4]

    // Restart unlock: two keys.
    kwd_seq #(
        .KEY1(KWD_KEY_RST1),
        .KEY2(KWD_KEY_RST2),
        .THIRD(1'b0)
    ) u_kick_seq (
        .clk_i(clk_i),
        .rst_n_i(sys_rst_n),
        .wr_i(ctrl_wr),
        .rd_i(ctrl_rd),
        .data_i(req.writedata[15:0]),
        .hit_o(kick_hit)
    ); // [R5] [R6]

    // Bus handshake and read data capture.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            ack_ff <= (req.read || req.write) && !ack_ff;
            if (req.read && !ack_ff)
            begin
                rdata_ff <= sel_ctrl ? {16'h0000, ctrl_view} : 32'h0000_0000;
            end
        end
    end

    // Configuration, written once per reset through the key sequence.
    always_ff @(posedge clk_i)
    begin
        if (!sys_rst_n)
        begin
            cfg_done_ff <= 1'b0;
            mode_ff <= KWD_MODE_RESET; // [R1]
            tsel_ff <= KWD_SEL_MAX; // [R1] [R8]
        end
        else if (cfg_hit && !cfg_done_ff)
        begin
            cfg_done_ff <= 1'b1; // [R2]
            mode_ff <= req.writedata[KWD_MODE_BIT]; // [R9]
            tsel_ff <= req.writedata[KWD_SEL_LSB +: KWD_SEL_W]; // [R18]
        end
    end

    // Counter advances every clock and restarts on a kick or timeout.
    assign limit = sel_limit(tsel_ff);
    // A shorter selection written mid-count still ends the period.
    assign timeout = (cnt_ff >= limit); // [R18]

    always_ff @(posedge clk_i)
    begin
        if (!sys_rst_n || kick_hit || timeout)
        begin
            cnt_ff <= '0; // [R5]
        end
        else
        begin
            cnt_ff <= cnt_ff + 1'b1; // [R18]
        end
    end

    // Interrupt flag: survives a watchdog reset, cleared by power-on
    // or by a keyed configuration write with the bit low. A set flag
    // is cleared even if a timeout falls in the same cycle.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            irq_flag_ff <= 1'b0; // [R19]
            nmi_ff <= 1'b0;
        end
        else
        begin
            nmi_ff <= 1'b0;
            if (timeout && mode_ff == KWD_MODE_NMI && !irq_flag_ff)
            begin
                irq_flag_ff <= 1'b1; // [R10]
                nmi_ff <= 1'b1;
            end
            else if (cfg_hit && !cfg_done_ff &&
                     !req.writedata[KWD_IRQ_FLAG_BIT])
            begin
                irq_flag_ff <= 1'b0;
            end
        end
    end

    // Watchdog reset pulse and reset flag. The flag is set by the reset
    // and cleared by any control access; the set wins.
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            rst_flag_ff <= 1'b0; // [R19]
            wdt_rst_ff <= 1'b0;
            rst_cnt_ff <= 3'h0;
        end
        else
        begin
            if (timeout && (mode_ff == KWD_MODE_RESET || irq_flag_ff))
            begin
                wdt_rst_ff <= 1'b1; // [R13]
                rst_cnt_ff <= 3'(KWD_RST_PULSE - 1);
                rst_flag_ff <= 1'b1; // [R14]
            end
            else
            begin
                if (rst_cnt_ff != 3'h0)
                begin
                    rst_cnt_ff <= rst_cnt_ff - 3'h1;
                end
                else
                begin
                    wdt_rst_ff <= 1'b0;
                end
                if (ctrl_wr || ctrl_rd)
                begin
                    rst_flag_ff <= 1'b0; // [R15]
                end
            end
        end
    end

    // Outputs. Pin-sampled configuration lives outside and only sees
    // the power-on reset, never this pulse.
    assign wdt_nmi_o = nmi_ff;
    assign wdt_rst_o = wdt_rst_ff; // [R16] [R17]

endmodule

/* tb_top.sv */
/* Self-checking bench for the keyed watchdog.
   Assumes a 64-cycle longest timeout and one wait cycle per access. */
`timescale 1ns/1ps
module tb_top;
    import kwd_pkg::*;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic wdt_nmi_o;
    logic wdt_rst_o;
    int bad_count = 0;
    int num_checks = 0;
    int n;
    kwd_top #(.MAX_CYC(64)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o),
        .wdt_nmi_o(wdt_nmi_o), .wdt_rst_o(wdt_rst_o));
    // A 50 MHz clock.
    always #10 clk_i = ~clk_i;
    task automatic close_out;
        if (bad_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            bad_count++;
            $display("BAD %0t %h %h", $time, s, e);
        end
    endtask
    // One Avalon-MM access, held until waitrequest is seen low.
    task automatic bus(input logic w, input logic [3:0] a,
        input logic [15:0] d, output logic [31:0] q);
        @(posedge clk_i);
        avs_write_i <= w;
        avs_read_i <= !w;
        avs_address_i <= a;
        avs_writedata_i <= {16'h0000, d};
        do
            @(posedge clk_i);
        while (avs_waitrequest_o);
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, KWD_CTRL_ADDR, d, q);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        logic [31:0] q;
        bus(1'b0, a, 16'h0000, q);
        chk(q, {16'h0000, e});
    endtask
    // Counts cycles until an interrupt or reset pulse, up to lim.
    task automatic wait_ev(input bit nmi, input int lim, output int c);
        c = 0;
        while (!(nmi ? wdt_nmi_o : wdt_rst_o) && c < lim)
        begin
            @(negedge clk_i);
            c++;
        end
    endtask
    task automatic do_rst;
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
    endtask
    // Main sequence.
    initial
    begin
        do_rst();
        rd(4'h0, 16'h0007);
        wait_ev(1'b0, 200, n);
        chk(32'(n > 50 && n < 68), 32'h1);
        repeat (8) @(posedge clk_i);
        rd(4'h0, 16'h2007);
        rd(4'h0, 16'h0007);
        wr(KWD_KEY_CFG1);
        rd(4'h4, 16'h0000);
        wr(KWD_KEY_CFG2);
        wr(16'h8007);
        rd(4'h0, 16'h8007);
        wr(KWD_KEY_CFG1);
        wr(KWD_KEY_CFG2);
        wr(16'h0007);
        rd(4'h0, 16'h8007);
        wait_ev(1'b1, 200, n);
        chk(32'(n < 200), 32'h1);
        rd(4'h0, 16'h9007);
        wait_ev(1'b0, 200, n);
        chk(32'(n < 200), 32'h1);
        repeat (8) @(posedge clk_i);
        rd(4'h0, 16'h3007);
        wr(KWD_KEY_CFG1);
        wr(KWD_KEY_CFG2);
        wr(16'h8007);
        rd(4'h0, 16'h8007);
        do_rst();
        rd(4'h0, 16'h0007);
        // Keep the count alive past its timeout with four restarts.
        repeat (4)
        begin
            wait_ev(1'b0, 30, n);
            chk(32'(n), 32'd30);
            wr(KWD_KEY_RST1);
            wr(KWD_KEY_RST2);
        end
        wr(KWD_KEY_RST1);
        rd(4'h0, 16'h0007);
        wr(KWD_KEY_RST2);
        wait_ev(1'b0, 80, n);
        chk(32'(n < 61), 32'h1);
        do_rst();
        wr(KWD_KEY_CFG1);
        wr(KWD_KEY_CFG2);
        wr(16'h0006);
        wait_ev(1'b0, 24, n);
        chk(32'(n < 24), 32'h1);
        close_out();
    end
    // Cuts a hang short.
    initial
    begin
        repeat (3000) @(posedge clk_i);
        bad_count++;
        close_out();
    end
endmodule
